// ==== rcsoc_defines.vh ====
/*
  Constants of the reset cause and slow oscillator control block:
  register offsets, field positions, reset values and timing counts.
  Assumes it is included by its bare name from the design modules.
*/
`ifndef RCSOC_DEFINES_VH
`define RCSOC_DEFINES_VH

`define RCSOC_ADDR_W 8
`define RCSOC_OFF_CLOCK_CONTROL_MAIN 8'h00
`define RCSOC_OFF_CSR 8'h60
`define RCSOC_OFF_INT_STATUS 8'h64
`define RCSOC_OFF_INT_MASK 8'h68

`define RCSOC_BIT_WATCHDOG_FLAG 29
`define RCSOC_BIT_SOFTWARE_FLAG 28
`define RCSOC_BIT_POWER_FLAG 27
`define RCSOC_BIT_PIN_FLAG 26
`define RCSOC_BIT_OPTION_FLAG 25
`define RCSOC_FLAG_HI 30
`define RCSOC_FLAG_LO 25
`define RCSOC_BIT_FLAG_CLEAR 23
`define RCSOC_BIT_FILTER_DISABLE 8
`define RCSOC_BIT_OSC_READY 1
`define RCSOC_BIT_OSC_ENABLE 0

`define RCSOC_INT_W 6
`define RCSOC_INT_OSC_READY 5

`define RCSOC_CSR_RESET 32'h00000000
`define RCSOC_INT_RESET 6'h00

`define RCSOC_CLOCK_MHZ 40
`define RCSOC_FILTER_US 20
// Filter width in clocks: RCSOC_FILTER_US times RCSOC_CLOCK_MHZ, sized to the counter.
`define RCSOC_FILTER_CYCLES 10'd800
`define RCSOC_FILTER_CNT_W 10

`endif

// ==== rcsoc_pin_filter.v ====
/*
  Pulse-width filter for the external reset pin.
  Assumes the raw pin is asynchronous and active low, and that i_por_rst_n
  is the power-on reset already released synchronously to i_clock.
*/
`timescale 1ns/100ps
`include "rcsoc_defines.vh"

module rcsoc_pin_filter #(
  parameter CNT_W = `RCSOC_FILTER_CNT_W,
  parameter [CNT_W-1:0] FILTER_CYCLES = `RCSOC_FILTER_CYCLES
) (
  // Clock and reset.
  input wire i_clock,
  input wire i_por_rst_n,
  // Pin and control.
  input wire i_external_reset_pin_n,
  input wire i_reset_pin_filter_disable,
  // Filtered request.
  output reg o_pin_reset_req_ff
);

  reg pin_meta_ff;
  reg pin_sync_n_ff;
  reg [CNT_W-1:0] low_count_ff;
  reg [CNT_W-1:0] nxt_low_count;
  reg nxt_pin_reset_req;

  //////////////////////////////////////////////////////////////////////////////
  always @(posedge i_clock or negedge i_por_rst_n) begin
    if (!i_por_rst_n) begin
      pin_meta_ff <= 1'b1;
      pin_sync_n_ff <= 1'b1;
    end else begin
      pin_meta_ff <= i_external_reset_pin_n;
      pin_sync_n_ff <= pin_meta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  always @* begin
    nxt_low_count = {CNT_W{1'b0}};
    nxt_pin_reset_req = 1'b0;
    if (i_reset_pin_filter_disable) begin
      nxt_pin_reset_req = ~pin_sync_n_ff; // see [R8]
    end else if (!pin_sync_n_ff) begin
      if (low_count_ff >= FILTER_CYCLES - 1'b1) begin
        nxt_low_count = low_count_ff;
        nxt_pin_reset_req = 1'b1; // see [R8]
      end else begin
        nxt_low_count = low_count_ff + 1'b1;
      end
    end
  end

  always @(posedge i_clock or negedge i_por_rst_n) begin
    if (!i_por_rst_n) begin
      low_count_ff <= {CNT_W{1'b0}};
      o_pin_reset_req_ff <= 1'b0;
    end else begin
      low_count_ff <= nxt_low_count;
      o_pin_reset_req_ff <= nxt_pin_reset_req;
    end
  end

endmodule

// ==== rcsoc_top.v ====
/*
  Reset cause and slow oscillator control register with its event
  interrupt and the reset pin filter.
  Assumes a simple register port on i_clock, event inputs that are
  asynchronous levels, and a power-on reset that also covers system reset.
*/
// Decided for this implementation: strobed register access.
`timescale 1ns/100ps
`include "rcsoc_defines.vh"

// Operation
// [R1] Flags cleared by power-on; enable by system reset.
// [R2] Bit 29 records watchdog reset until cleared.
// [R3] Bit 28 records software reset until cleared.
// [R4] Bit 27 records power supervisor reset.
// [R5] Bit 26 records external reset pin reset.
// [R6] Bit 25 records option loader reset.
// [R7] Writing one to bit 23 clears flags.
// [R8] Bit 8 bypasses pin filter, stops oscillator.
// [R9] Bit 1 shows slow oscillator stable.
// [R10] Bit 0 enables slow oscillator, software writable.
// [R11] Hardware forces enable for watchdog or security.
// [R12] Writes to read-only flags are ignored.
module rcsoc_top (
  // Clock and resets.
  input wire i_clock,
  input wire i_reset_n,
  input wire i_por_n,
  // Register port.
  input wire [`RCSOC_ADDR_W-1:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_write,
  input wire i_read,
  output reg [31:0] o_rdata_ff,
  // Reset cause events.
  input wire i_watchdog_reset_evt,
  input wire i_software_reset_evt,
  input wire i_power_reset_evt,
  input wire i_option_loader_reset_evt,
  // External reset pin.
  input wire i_external_reset_pin_n,
  output reg o_pin_reset_req_ff,
  output reg o_internal_10mhz_osc_enable_ff,
  // Slow oscillator.
  input wire i_slow_osc_stable,
  input wire i_watchdog_hw_enable,
  input wire i_external_slow_clock_security,
  output reg o_slow_internal_osc_enable_ff,
  // Interrupt.
  output reg o_irq_ff
);

  reg por_meta_ff;
  reg por_rst_n_ff;
  reg sys_meta_ff;
  reg sys_rst_n_ff;
  wire sys_rst_src_n;

  reg [3:0] evt_meta_ff;
  reg [3:0] evt_sync_ff;
  reg [3:0] stat_meta_ff;
  reg [2:0] stat_sync_ff;

  reg [`RCSOC_FLAG_HI:`RCSOC_FLAG_LO] flags_ff;
  reg [`RCSOC_FLAG_HI:`RCSOC_FLAG_LO] nxt_flags;
  reg [`RCSOC_FLAG_HI:`RCSOC_FLAG_LO] flag_set;
  reg filter_disable_ff;
  reg osc_enable_ff;
  reg nxt_osc_enable;
  reg osc_ready_ff;
  reg [`RCSOC_INT_W-1:0] int_status_ff;
  reg [`RCSOC_INT_W-1:0] nxt_int_status;
  reg [`RCSOC_INT_W-1:0] int_mask_ff;
  reg [`RCSOC_INT_W-1:0] int_event;
  reg [`RCSOC_INT_W-1:0] evt_prev_ff;
  reg [31:0] nxt_rdata;
  wire pin_req;

  wire wr_csr;
  wire wr_status;
  wire wr_mask;
  wire flag_clear;

  //////////////////////////////////////////////////////////////////////////////
  // Decodes a register offset against the bus address.
  function hit;
    input [`RCSOC_ADDR_W-1:0] addr;
    input [`RCSOC_ADDR_W-1:0] offset;
    begin
      hit = (addr == offset);
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // Power-on reset release.
  always @(posedge i_clock or negedge i_por_n) begin
    if (!i_por_n) begin
      por_meta_ff <= 1'b0;
      por_rst_n_ff <= 1'b0;
    end else begin
      por_meta_ff <= 1'b1;
      por_rst_n_ff <= por_meta_ff;
    end
  end

  // System reset release; power-on reset also acts as a system reset.
  assign sys_rst_src_n = i_reset_n & i_por_n;

  always @(posedge i_clock or negedge sys_rst_src_n) begin
    if (!sys_rst_src_n) begin
      sys_meta_ff <= 1'b0;
      sys_rst_n_ff <= 1'b0;
    end else begin
      sys_meta_ff <= 1'b1;
      sys_rst_n_ff <= sys_meta_ff;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Event and status synchronisers, kept alive through system reset.
  always @(posedge i_clock or negedge por_rst_n_ff) begin
    if (!por_rst_n_ff) begin
      evt_meta_ff <= 4'h0;
      evt_sync_ff <= 4'h0;
    end else begin
      evt_meta_ff <= {i_watchdog_reset_evt, i_software_reset_evt,
                      i_power_reset_evt, i_option_loader_reset_evt};
      evt_sync_ff <= evt_meta_ff;
    end
  end

  always @(posedge i_clock or negedge por_rst_n_ff) begin
    if (!por_rst_n_ff) begin
      stat_meta_ff <= 4'h0;
      stat_sync_ff <= 3'h0;
    end else begin
      stat_meta_ff <= {1'b0, i_slow_osc_stable, i_watchdog_hw_enable,
                       i_external_slow_clock_security};
      stat_sync_ff <= stat_meta_ff[2:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // External reset pin filter.
  rcsoc_pin_filter #(
    .CNT_W(`RCSOC_FILTER_CNT_W),
    .FILTER_CYCLES(`RCSOC_FILTER_CYCLES)
  ) u_pin_filter (
    .i_clock(i_clock),
    .i_por_rst_n(por_rst_n_ff),
    .i_external_reset_pin_n(i_external_reset_pin_n),
    .i_reset_pin_filter_disable(filter_disable_ff),
    .o_pin_reset_req_ff(pin_req)
  );

  //////////////////////////////////////////////////////////////////////////////
  // Write decode.
  assign wr_csr = i_write & hit(i_addr, `RCSOC_OFF_CSR);
  assign wr_status = i_write & hit(i_addr, `RCSOC_OFF_INT_STATUS);
  assign wr_mask = i_write & hit(i_addr, `RCSOC_OFF_INT_MASK);
  assign flag_clear = wr_csr & i_wdata[`RCSOC_BIT_FLAG_CLEAR]; // see [R7]

  //////////////////////////////////////////////////////////////////////////////
  // Reset cause flags; a new cause wins over a clear in the same cycle.
  always @* begin
    flag_set = 6'h00;
    flag_set[`RCSOC_BIT_WATCHDOG_FLAG] = evt_sync_ff[3]; // see [R2]
    flag_set[`RCSOC_BIT_SOFTWARE_FLAG] = evt_sync_ff[2]; // see [R3]
    flag_set[`RCSOC_BIT_POWER_FLAG] = evt_sync_ff[1]; // see [R4]
    flag_set[`RCSOC_BIT_PIN_FLAG] = pin_req; // see [R5]
    flag_set[`RCSOC_BIT_OPTION_FLAG] = evt_sync_ff[0]; // see [R6]
    nxt_flags = flags_ff;
    if (flag_clear) begin
      nxt_flags = 6'h00; // see [R7]
    end
    nxt_flags = nxt_flags | flag_set; // see [R12]
  end

  always @(posedge i_clock or negedge por_rst_n_ff) begin
    if (!por_rst_n_ff) begin
      flags_ff <= 6'h00; // see [R1]
    end else begin
      flags_ff <= nxt_flags;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin filter disable survives system reset.
  always @(posedge i_clock or negedge por_rst_n_ff) begin
    if (!por_rst_n_ff) begin
      filter_disable_ff <= 1'b0; // see [R1]
      o_internal_10mhz_osc_enable_ff <= 1'b1;
    end else begin
      if (wr_csr) begin
        filter_disable_ff <= i_wdata[`RCSOC_BIT_FILTER_DISABLE];
      end
      o_internal_10mhz_osc_enable_ff <= ~filter_disable_ff; // see [R8]
    end
  end

  always @(posedge i_clock or negedge por_rst_n_ff) begin
    if (!por_rst_n_ff) begin
      o_pin_reset_req_ff <= 1'b0;
    end else begin
      o_pin_reset_req_ff <= pin_req; // see [R8]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Slow oscillator enable and ready.
  always @* begin
    nxt_osc_enable = osc_enable_ff;
    if (wr_csr) begin
      nxt_osc_enable = i_wdata[`RCSOC_BIT_OSC_ENABLE]; // see [R10]
    end
    if (stat_sync_ff[1] | stat_sync_ff[0]) begin
      nxt_osc_enable = 1'b1; // see [R11]
    end
  end

  always @(posedge i_clock or negedge sys_rst_n_ff) begin
    if (!sys_rst_n_ff) begin
      osc_enable_ff <= 1'b0; // see [R1]
      o_slow_internal_osc_enable_ff <= 1'b0;
      osc_ready_ff <= 1'b0;
    end else begin
      osc_enable_ff <= nxt_osc_enable;
      o_slow_internal_osc_enable_ff <= nxt_osc_enable;
      osc_ready_ff <= stat_sync_ff[2] & osc_enable_ff; // see [R9]
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Interrupt status: rising edges of each cause and of oscillator ready.
  always @* begin
    int_event = {osc_ready_ff, flag_set[`RCSOC_BIT_WATCHDOG_FLAG:`RCSOC_FLAG_LO]} & ~evt_prev_ff;
    nxt_int_status = int_status_ff;
    if (wr_status) begin
      nxt_int_status = int_status_ff & ~i_wdata[`RCSOC_INT_W-1:0];
    end
    nxt_int_status = nxt_int_status | int_event;
  end

  always @(posedge i_clock or negedge por_rst_n_ff) begin
    if (!por_rst_n_ff) begin
      evt_prev_ff <= `RCSOC_INT_RESET;
      int_status_ff <= `RCSOC_INT_RESET;
      int_mask_ff <= `RCSOC_INT_RESET;
      o_irq_ff <= 1'b0;
    end else begin
      evt_prev_ff <= {osc_ready_ff, flag_set[`RCSOC_BIT_WATCHDOG_FLAG:`RCSOC_FLAG_LO]};
      int_status_ff <= nxt_int_status;
      if (wr_mask) begin
        int_mask_ff <= i_wdata[`RCSOC_INT_W-1:0];
      end
      o_irq_ff <= |(nxt_int_status & (wr_mask ? i_wdata[`RCSOC_INT_W-1:0] : int_mask_ff));
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Read mux; unmapped offsets read as zero.
  always @* begin
    nxt_rdata = 32'h00000000;
    if (hit(i_addr, `RCSOC_OFF_CSR)) begin
      nxt_rdata[`RCSOC_FLAG_HI:`RCSOC_FLAG_LO] = flags_ff;
      nxt_rdata[`RCSOC_BIT_FILTER_DISABLE] = filter_disable_ff;
      nxt_rdata[`RCSOC_BIT_OSC_READY] = osc_ready_ff; // see [R9]
      nxt_rdata[`RCSOC_BIT_OSC_ENABLE] = osc_enable_ff;
    end else if (hit(i_addr, `RCSOC_OFF_INT_STATUS)) begin
      nxt_rdata[`RCSOC_INT_W-1:0] = int_status_ff;
    end else if (hit(i_addr, `RCSOC_OFF_INT_MASK)) begin
      nxt_rdata[`RCSOC_INT_W-1:0] = int_mask_ff;
    end
  end

  always @(posedge i_clock or negedge sys_rst_n_ff) begin
    if (!sys_rst_n_ff) begin
      o_rdata_ff <= `RCSOC_CSR_RESET;
    end else if (i_read) begin
      o_rdata_ff <= nxt_rdata;
    end else begin
      o_rdata_ff <= 32'h00000000;
    end
  end

endmodule

// ==== rcsoc_properties.sv ====
/*
  Port checker for the reset cause and slow oscillator control block.
  Assumes it is bound to rcsoc_top and sees only its ports.
*/
`timescale 1ns/100ps
module rcsoc_properties (
  // Clock and resets.
  input wire i_clock,
  input wire i_reset_n,
  input wire i_por_n,
  // Register port.
  input wire [7:0] i_addr,
  input wire i_read,
  input wire [31:0] o_rdata_ff,
  // Pin and oscillator.
  input wire i_external_reset_pin_n,
  input wire o_pin_reset_req_ff,
  input wire o_internal_10mhz_osc_enable_ff,
  input wire i_slow_osc_stable,
  input wire i_watchdog_hw_enable,
  input wire i_external_slow_clock_security,
  input wire o_slow_internal_osc_enable_ff
);
  wire csr_rd = i_read && i_addr == 8'h60;
  wire osc_en = o_slow_internal_osc_enable_ff;
  reg [10:0] low_cnt_ff = 11'h000;
  // Counts raw cycles with the pin held low.
  always @(posedge i_clock) begin
    low_cnt_ff <= i_external_reset_pin_n ? 11'h000 : low_cnt_ff + {10'h000, ~&low_cnt_ff};
  end
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_reset_n || !i_por_n);
  ////////////////////////////////////////
  AST_RD_IDLE: assert property (!$past(i_read) |-> o_rdata_ff == 32'h0)
    else $error("read data not zero outside a read");
  AST_RESERVED: assert property (csr_rd |=> (o_rdata_ff & 32'hc1fffefc) == 32'h0)
    else $error("reserved bits read nonzero");
  AST_EN_READ: assert property (csr_rd |=> o_rdata_ff[0] == $past(osc_en))
    else $error("enable bit does not match output");
  AST_RDY_EN: assert property (csr_rd |=> !o_rdata_ff[1] || $past(osc_en, 2) || $past(osc_en))
    else $error("ready without enable");
  AST_RDY_LOW: assert property ((!i_slow_osc_stable)[*5] ##0 csr_rd |=> !o_rdata_ff[1])
    else $error("ready while unstable");
  AST_FORCE: assert property ((i_watchdog_hw_enable || i_external_slow_clock_security)[*8]
    |-> osc_en)
    else $error("enable not forced");
  AST_FILTER: assert property ($rose(o_pin_reset_req_ff) && o_internal_10mhz_osc_enable_ff
    |-> low_cnt_ff >= 11'd800)
    else $error("pin request before filter width");
  AST_PIN_OFF: assert property (i_external_reset_pin_n[*6] |-> !o_pin_reset_req_ff)
    else $error("pin request while pin high");
  AST_BYPASS: assert property ((!o_internal_10mhz_osc_enable_ff && !i_external_reset_pin_n)[*6]
    |-> o_pin_reset_req_ff)
    else $error("bypassed pin request late");
endmodule
bind rcsoc_top rcsoc_properties chk_u (.i_clock, .i_reset_n, .i_por_n, .i_addr, .i_read,
  .o_rdata_ff, .i_external_reset_pin_n, .o_pin_reset_req_ff, .o_internal_10mhz_osc_enable_ff,
  .i_slow_osc_stable, .i_watchdog_hw_enable, .i_external_slow_clock_security,
  .o_slow_internal_osc_enable_ff);

// ==== rcsoc_top_tb_top.sv ====
/*
  Self-checking testbench of the reset cause and slow oscillator block.
  Assumes rcsoc_top and its checker are compiled before it.
*/
`timescale 1ns/100ps
module rcsoc_top_tb_top;
  reg i_clock = 1'b0;
  reg i_reset_n = 1'b0;
  reg i_por_n = 1'b0;
  reg [7:0] i_addr = 8'h00;
  reg [31:0] i_wdata = 32'h0;
  reg i_write = 1'b0;
  reg i_read = 1'b0;
  reg [3:0] ev = 4'h0;
  reg pin_n = 1'b1;
  reg stable = 1'b0;
  reg [1:0] frc = 2'h0;
  wire [31:0] rdata;
  wire req, osc10, osc_en, irq;
  int n_errors = 0;
  int checks = 0;
  always #12.5 i_clock = ~i_clock;
  rcsoc_top dut_u (.i_clock(i_clock), .i_reset_n(i_reset_n), .i_por_n(i_por_n),
    .i_addr(i_addr), .i_wdata(i_wdata), .i_write(i_write), .i_read(i_read),
    .o_rdata_ff(rdata), .i_watchdog_reset_evt(ev[3]), .i_software_reset_evt(ev[2]),
    .i_power_reset_evt(ev[1]), .i_option_loader_reset_evt(ev[0]),
    .i_external_reset_pin_n(pin_n), .o_pin_reset_req_ff(req),
    .o_internal_10mhz_osc_enable_ff(osc10), .i_slow_osc_stable(stable),
    .i_watchdog_hw_enable(frc[0]), .i_external_slow_clock_security(frc[1]),
    .o_slow_internal_osc_enable_ff(osc_en), .o_irq_ff(irq));
  ////////////////////////////////////////
  task check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge i_clock);
    i_addr <= a;
    i_wdata <= d;
    i_write <= 1'b1;
    @(posedge i_clock);
    i_write <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] exp);
    @(posedge i_clock);
    i_addr <= a;
    i_read <= 1'b1;
    @(posedge i_clock);
    i_read <= 1'b0;
    @(negedge i_clock);
    check(rdata, exp);
  endtask
  task summarize;
    $display("errors %0d checks %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////
  task t_por;
    i_por_n <= 1'b0;
    repeat (3) @(posedge i_clock);
    i_por_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    rdc(8'h60, 32'h0);
    rdc(8'h64, 32'h0);
    rdc(8'h68, 32'h0);
    rdc(8'h00, 32'h0);
    rdc(8'h10, 32'h0);
    check({31'h0, osc10}, 32'h1);
  endtask
  task t_flags;
    logic [31:0] exp;
    exp = 32'h0;
    for (int k = 0; k < 4; k++) begin
      ev <= 4'h1 << k;
      repeat (5) @(posedge i_clock);
      ev <= 4'h0;
      exp[k == 0 ? 25 : 26 + k] = 1'b1;
      rdc(8'h60, exp);
    end
    wr(8'h60, 32'h7e000002);
    rdc(8'h60, 32'h3a000000);
    rdc(8'h64, 32'h0000001d);
    wr(8'h68, 32'h10);
    repeat (2) @(posedge i_clock);
    check({31'h0, irq}, 32'h1);
    wr(8'h64, 32'h10);
    repeat (2) @(posedge i_clock);
    check({31'h0, irq}, 32'h0);
    rdc(8'h64, 32'h0000000d);
    wr(8'h60, 32'h00800000);
    rdc(8'h60, 32'h0);
  endtask
  task t_pin;
    pin_n <= 1'b0;
    repeat (700) @(posedge i_clock);
    check({31'h0, req}, 32'h0);
    repeat (110) @(posedge i_clock);
    check({31'h0, req}, 32'h1);
    pin_n <= 1'b1;
    repeat (6) @(posedge i_clock);
    rdc(8'h60, 32'h04000000);
    wr(8'h60, 32'h100);
    repeat (2) @(posedge i_clock);
    check({31'h0, osc10}, 32'h0);
    pin_n <= 1'b0;
    repeat (8) @(posedge i_clock);
    check({31'h0, req}, 32'h1);
    pin_n <= 1'b1;
    repeat (6) @(posedge i_clock);
  endtask
  task t_sys_reset;
    wr(8'h60, 32'h101);
    repeat (2) @(posedge i_clock);
    check({31'h0, osc_en}, 32'h1);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clock);
    i_reset_n <= 1'b1;
    repeat (4) @(posedge i_clock);
    rdc(8'h60, 32'h04000100);
    check({31'h0, osc_en}, 32'h0);
  endtask
  task t_osc;
    stable <= 1'b1;
    wr(8'h60, 32'h101);
    repeat (6) @(posedge i_clock);
    rdc(8'h60, 32'h04000103);
    rdc(8'h64, 32'h0000002f);
    wr(8'h60, 32'h100);
    repeat (2) @(posedge i_clock);
    rdc(8'h60, 32'h04000100);
    for (int k = 0; k < 2; k++) begin
      frc <= 2'h1 << k;
      repeat (5) @(posedge i_clock);
      wr(8'h60, 32'h100);
      repeat (2) @(posedge i_clock);
      check({31'h0, osc_en}, 32'h1);
      frc <= 2'h0;
      repeat (4) @(posedge i_clock);
      wr(8'h60, 32'h100);
      repeat (2) @(posedge i_clock);
      check({31'h0, osc_en}, 32'h0);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    repeat (3) @(posedge i_clock);
    i_reset_n <= 1'b1;
    t_por;
    t_flags;
    t_pin;
    t_sys_reset;
    t_osc;
    t_por;
    summarize;
  end
  initial begin
    #200000;
    n_errors++;
    summarize;
  end
endmodule
